// File: design/rgb_strobe_switch_sequencer.sv
// How it works
// - Offset rail 100 ms, bias/reset 10 ms later.
// - Driver and decoder off until rails up.
// - Any rail fault drops all three together.
// - Request level and mirror enable start power-up or power-down sequences.
// - Mirror and LED enable bits reset high.
// - Package bit picks anode or cathode map.
// - Anode map: codes 1-3 pick currents.
// - Anode select 3 closes six, three, two, one.
// - Cathode map: 0 all open, 1 six/one.
// - Cathode selects 2 and 3 patterns, currents.
// - Open leaving switches before closing new ones.
// - Dead time is the break-before-make delay setting plus one clock.
// - Switches closed in both patterns stay closed.
// - Selected colour routes its own current code.
// - Serial output changes on falling clock, releases.
// - Colour selects deglitched about 300 ns.
// - Power request deglitched about 1 ms.
`timescale 1ns/100ps
`default_nettype none
`include "strobe_sequencer_cfg.svh"
module rgb_strobe_switch_sequencer #(
   parameter int OFFSET_DELAY_CYCLES = `OFFSET_RAIL_DELAY_CYCLES,
   parameter int BIAS_DELAY_CYCLES = `BIAS_RAIL_DELAY_CYCLES,
   parameter int POWER_DEGLITCH_CYCLES = `POWER_DEGLITCH_CYCLES,
   parameter int BBM_WIDTH = 8
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic projector_power_request_in,
   input wire logic [1:0] colour_select_in,
   input wire logic package_map_in,
   input wire logic [2:0] rail_fault_in,
   input wire logic mirror_enable_write_in,
   input wire logic mirror_enable_value_in,
   input wire logic led_enable_write_in,
   input wire logic led_enable_value_in,
   input wire logic [BBM_WIDTH-1:0] break_before_make_delay_in,
   input wire logic [`CURRENT_CODE_WIDTH-1:0] first_colour_current_code_in,
   input wire logic [`CURRENT_CODE_WIDTH-1:0] second_colour_current_code_in,
   input wire logic [`CURRENT_CODE_WIDTH-1:0] third_colour_current_code_in,
   input wire logic serial_clock_in,
   input wire logic serial_select_low_in,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_oe_low_out,
   output logic [`SERIAL_WORD_WIDTH-1:0] serial_rx_word_out,
   output logic serial_rx_valid_out,
   output logic offset_rail_enable_out,
   output logic bias_rail_enable_out,
   output logic mirror_reset_rail_enable_out,
   output logic led_driver_enable_out,
   output logic full_active_state_out,
   output logic mirror_supply_enable_out,
   output logic led_supply_enable_out,
   output logic rail_fault_latched_out,
   output strobe_sequencer_pkg::switch_map_t switch_closed_out,
   output logic [`CURRENT_CODE_WIDTH-1:0] current_code_out,
   output logic current_code_valid_out
);
   import strobe_sequencer_pkg::*;

   localparam int CW = `SEQ_COUNT_WIDTH;
   localparam logic [3:0] COLOUR_DEGLITCH = 4'(`COLOUR_DEGLITCH_CYCLES);

   generate
      if (OFFSET_DELAY_CYCLES < 1 || OFFSET_DELAY_CYCLES >= (1 << CW) ||
          BIAS_DELAY_CYCLES < 1 || BIAS_DELAY_CYCLES >= (1 << CW) ||
          POWER_DEGLITCH_CYCLES < 1 || POWER_DEGLITCH_CYCLES >= (1 << CW) ||
          BBM_WIDTH < 1 || BBM_WIDTH > 16) begin : g_bad_params
         $error("Sequencer parameters out of range.");
      end
   endgenerate

   // The request, colour, serial and fault pins pass two flip-flops before any logic looks at them.
   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         // The select bit resets to its idle high level, so no false frame edge follows reset.
         sync1_q <= 8'h08;
         sync2_q <= 8'h08;
      end else begin
         sync1_q <= {rail_fault_in, serial_data_in, serial_select_low_in, serial_clock_in,
                     colour_select_in};
         sync2_q <= sync1_q;
      end
   end
   logic req_sync1_q;
   logic req_sync2_q;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         req_sync1_q <= 1'b0;
         req_sync2_q <= 1'b0;
      end else begin
         req_sync1_q <= projector_power_request_in;
         req_sync2_q <= req_sync1_q;
      end
   end
   logic [1:0] colour_sync;
   logic sclk_sync;
   logic cs_low_sync;
   logic din_sync;
   logic [2:0] fault_sync;
   assign colour_sync = sync2_q[1:0];
   assign sclk_sync = sync2_q[2];
   assign cs_low_sync = sync2_q[3];
   assign din_sync = sync2_q[4];
   assign fault_sync = sync2_q[7:5];

   // A new request level is taken only after it has held for the whole filter time.
   logic req_f_q;
   logic [CW-1:0] req_cnt_q;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         req_f_q <= 1'b0;
         req_cnt_q <= '0;
      end else if (req_sync2_q == req_f_q) begin
         req_cnt_q <= '0;
      end else if (req_cnt_q == CW'(POWER_DEGLITCH_CYCLES - 1)) begin
         req_f_q <= req_sync2_q;
         req_cnt_q <= '0;
      end else begin
         req_cnt_q <= req_cnt_q + 1'b1;
      end
   end

   logic [1:0] colour_f_q;
   logic [3:0] colour_cnt_q;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         colour_f_q <= 2'h0;
         colour_cnt_q <= 4'h0;
      end else if (colour_sync == colour_f_q) begin
         colour_cnt_q <= 4'h0;
      end else if (colour_cnt_q == COLOUR_DEGLITCH - 4'h1) begin
         colour_f_q <= colour_sync;
         colour_cnt_q <= 4'h0;
      end else begin
         colour_cnt_q <= colour_cnt_q + 4'h1;
      end
   end

   logic req_f_prev_q;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         req_f_prev_q <= 1'b0;
      end else begin
         req_f_prev_q <= req_f_q;
      end
   end
   logic req_rise;
   assign req_rise = req_f_q & ~req_f_prev_q;

   logic any_fault;
   logic fault_lock_q;
   logic mirror_en_q;
   logic led_en_q;
   assign any_fault = |fault_sync;

   // A fault clears the mirror enable and locks the rails off until the request is toggled.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mirror_en_q <= `MIRROR_ENABLE_RESET;
         led_en_q <= `LED_ENABLE_RESET;
         fault_lock_q <= 1'b0;
      end else begin
         if (any_fault && (offset_rail_enable_out || bias_rail_enable_out)) begin
            mirror_en_q <= 1'b0;
            fault_lock_q <= 1'b1;
         end else begin
            if (req_rise) begin
               mirror_en_q <= 1'b1;
            end else if (mirror_enable_write_in) begin
               mirror_en_q <= mirror_enable_value_in;
            end
            if (!req_f_q) begin
               fault_lock_q <= 1'b0;
            end
         end
         if (led_enable_write_in) begin
            led_en_q <= led_enable_value_in;
         end
      end
   end

   rail_state_t rail_q;
   logic [CW-1:0] rail_cnt_q;
   logic up_wanted;
   assign up_wanted = req_f_q & mirror_en_q & ~fault_lock_q;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rail_q <= RAIL_OFF;
         rail_cnt_q <= '0;
         offset_rail_enable_out <= 1'b0;
         bias_rail_enable_out <= 1'b0;
         mirror_reset_rail_enable_out <= 1'b0;
      end else if (any_fault && (offset_rail_enable_out || bias_rail_enable_out)) begin
         rail_q <= RAIL_OFF;
         offset_rail_enable_out <= 1'b0;
         bias_rail_enable_out <= 1'b0;
         mirror_reset_rail_enable_out <= 1'b0;
         rail_cnt_q <= '0;
      end else begin
         rail_cnt_q <= rail_cnt_q + 1'b1;
         unique case (rail_q)
            RAIL_OFF: begin
               rail_cnt_q <= '0;
               if (up_wanted) begin
                  rail_q <= RAIL_WAIT_OFFSET;
               end
            end
            RAIL_WAIT_OFFSET: begin
               if (!up_wanted) begin
                  rail_q <= RAIL_OFF;
               end else if (rail_cnt_q == CW'(OFFSET_DELAY_CYCLES - 1)) begin
                  offset_rail_enable_out <= 1'b1;
                  rail_cnt_q <= '0;
                  rail_q <= RAIL_WAIT_BIAS;
               end
            end
            RAIL_WAIT_BIAS: begin
               if (!up_wanted) begin
                  rail_cnt_q <= '0;
                  rail_q <= RAIL_POWER_DOWN;
               end else if (rail_cnt_q == CW'(BIAS_DELAY_CYCLES - 1)) begin
                  bias_rail_enable_out <= 1'b1;
                  mirror_reset_rail_enable_out <= 1'b1;
                  rail_q <= RAIL_ON;
               end
            end
            RAIL_ON: begin
               rail_cnt_q <= '0;
               if (!up_wanted) begin
                  // Power-down runs the rise in reverse: bias and reset first.
                  bias_rail_enable_out <= 1'b0;
                  mirror_reset_rail_enable_out <= 1'b0;
                  rail_q <= RAIL_POWER_DOWN;
               end
            end
            RAIL_POWER_DOWN: begin
               if (rail_cnt_q == CW'(BIAS_DELAY_CYCLES - 1)) begin
                  offset_rail_enable_out <= 1'b0;
                  rail_q <= RAIL_OFF;
               end
            end
         endcase
      end
   end

   logic decoder_on;
   assign decoder_on = (rail_q == RAIL_ON) & offset_rail_enable_out & bias_rail_enable_out &
                       mirror_reset_rail_enable_out & led_en_q;

   switch_map_t target;
   logic [`CURRENT_CODE_WIDTH-1:0] target_code;
   always_comb begin
      target = `ANODE_SEL0;
      target_code = '0;
      unique case (colour_f_q)
         2'h0: begin
            target = package_map_in ? `CCA_SEL0 : `ANODE_SEL0;
         end
         2'h1: begin
            target = package_map_in ? `CCA_SEL1 : `ANODE_SEL1;
            target_code = first_colour_current_code_in;
         end
         2'h2: begin
            target = package_map_in ? `CCA_SEL2 : `ANODE_SEL2;
            target_code = second_colour_current_code_in;
         end
         2'h3: begin
            target = package_map_in ? `CCA_SEL3 : `ANODE_SEL3;
            target_code = third_colour_current_code_in;
         end
      endcase
      if (!decoder_on) begin
         target = 6'h00;
         target_code = '0;
      end
   end

   // If the target moves during the dead time, the opening phase is redone and the wait restarts.
   bbm_state_t bbm_q;
   logic [BBM_WIDTH-1:0] dead_cnt_q;
   switch_map_t goal_q;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bbm_q <= BBM_IDLE;
         dead_cnt_q <= '0;
         goal_q <= 6'h00;
         switch_closed_out <= 6'h00;
         current_code_out <= '0;
         current_code_valid_out <= 1'b0;
      end else begin
         unique case (bbm_q)
            BBM_IDLE: begin
               if (target != switch_closed_out) begin
                  switch_closed_out <= switch_closed_out & target;
                  goal_q <= target;
                  dead_cnt_q <= '0;
                  current_code_valid_out <= 1'b0;
                  bbm_q <= BBM_DEAD;
               end
            end
            BBM_DEAD: begin
               if (target != goal_q) begin
                  switch_closed_out <= switch_closed_out & target;
                  goal_q <= target;
                  dead_cnt_q <= '0;
               end else if (dead_cnt_q >= break_before_make_delay_in) begin
                  switch_closed_out <= goal_q;
                  current_code_out <= target_code;
                  current_code_valid_out <= (goal_q != 6'h00) && (colour_f_q != 2'h0);
                  bbm_q <= BBM_IDLE;
               end else begin
                  dead_cnt_q <= dead_cnt_q + 1'b1;
               end
            end
         endcase
      end
   end

   // The pins are sampled, so the serial clock must stay well below a quarter of clk_in.
   logic sclk_prev_q;
   logic cs_prev_q;
   logic [`SERIAL_WORD_WIDTH-1:0] tx_q;
   logic [`SERIAL_WORD_WIDTH-1:0] rx_q;
   switch_map_t status_sw;
   assign status_sw = switch_closed_out;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sclk_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
         tx_q <= '0;
         rx_q <= '0;
         serial_data_out <= 1'b0;
         serial_rx_word_out <= '0;
         serial_rx_valid_out <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_sync;
         cs_prev_q <= cs_low_sync;
         serial_rx_valid_out <= 1'b0;
         if (cs_prev_q && !cs_low_sync) begin
            tx_q <= {rail_fault_latched_out, full_active_state_out, offset_rail_enable_out,
                     bias_rail_enable_out, mirror_reset_rail_enable_out, mirror_en_q, led_en_q,
                     3'h0, status_sw};
            serial_data_out <= rail_fault_latched_out;
         end else if (!cs_low_sync && cs_prev_q == 1'b0) begin
            if (!sclk_prev_q && sclk_sync) begin
               rx_q <= {rx_q[`SERIAL_WORD_WIDTH-2:0], din_sync};
            end
            if (sclk_prev_q && !sclk_sync) begin
               tx_q <= {tx_q[`SERIAL_WORD_WIDTH-2:0], 1'b0};
               serial_data_out <= tx_q[`SERIAL_WORD_WIDTH-2];
            end
         end
         if (!cs_prev_q && cs_low_sync) begin
            serial_rx_word_out <= rx_q;
            serial_rx_valid_out <= 1'b1;
         end
      end
   end
   assign serial_data_oe_low_out = cs_low_sync;

   assign led_driver_enable_out = decoder_on;
   assign full_active_state_out = decoder_on & mirror_en_q;
   assign mirror_supply_enable_out = mirror_en_q;
   assign led_supply_enable_out = led_en_q;
   assign rail_fault_latched_out = fault_lock_q;
endmodule // rgb_strobe_switch_sequencer
`default_nettype wire

// File: pkg/strobe_sequencer_cfg.svh
`ifndef STROBE_SEQUENCER_CFG_SVH
`define STROBE_SEQUENCER_CFG_SVH

`define CLOCK_HZ 25000000
`define CLOCK_KHZ (`CLOCK_HZ / 1000)
`define OFFSET_RAIL_DELAY_MS 100
`define OFFSET_RAIL_DELAY_CYCLES (`OFFSET_RAIL_DELAY_MS * `CLOCK_KHZ)
`define BIAS_RAIL_DELAY_MS 10
`define BIAS_RAIL_DELAY_CYCLES (`BIAS_RAIL_DELAY_MS * `CLOCK_KHZ)
`define POWER_DEGLITCH_MS 1
`define POWER_DEGLITCH_CYCLES (`POWER_DEGLITCH_MS * `CLOCK_KHZ)
`define COLOUR_DEGLITCH_NS 300
`define COLOUR_DEGLITCH_CYCLES ((`COLOUR_DEGLITCH_NS * `CLOCK_KHZ + 999999) / 1000000)

`define SEQ_COUNT_WIDTH 22
`define CURRENT_CODE_WIDTH 10
`define SERIAL_WORD_WIDTH 16

`define MIRROR_ENABLE_RESET 1'b1
`define LED_ENABLE_RESET 1'b1

// Switch patterns, bit 5 is switch six down to bit 0 for switch one.
`define ANODE_SEL0 6'h07
`define ANODE_SEL1 6'h0F
`define ANODE_SEL2 6'h17
`define ANODE_SEL3 6'h27
`define CCA_SEL0 6'h00
`define CCA_SEL1 6'h21
`define CCA_SEL2 6'h1C
`define CCA_SEL3 6'h1A

`endif

// File: pkg/strobe_sequencer_pkg.sv
`default_nettype none
package strobe_sequencer_pkg;
   typedef enum logic [2:0] {
      RAIL_OFF,
      RAIL_WAIT_OFFSET,
      RAIL_WAIT_BIAS,
      RAIL_ON,
      RAIL_POWER_DOWN
   } rail_state_t;

   typedef enum logic [1:0] {
      BBM_IDLE,
      BBM_DEAD
   } bbm_state_t;

   typedef logic [5:0] switch_map_t;
endpackage
`default_nettype wire

// File: bench/strobe_sequencer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module strobe_sequencer_monitor #(
   parameter int BBM_WIDTH = 8
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [BBM_WIDTH-1:0] break_before_make_delay_in,
   input wire logic serial_select_low_in,
   input wire logic serial_data_oe_low_out,
   input wire logic offset_rail_enable_out,
   input wire logic bias_rail_enable_out,
   input wire logic mirror_reset_rail_enable_out,
   input wire logic led_driver_enable_out,
   input wire logic mirror_supply_enable_out,
   input wire logic led_supply_enable_out,
   input wire logic rail_fault_latched_out,
   input wire strobe_sequencer_pkg::switch_map_t switch_closed_out,
   input wire logic current_code_valid_out
);
   import strobe_sequencer_pkg::*;
   switch_map_t prev_q;
   logic [8:0] still_q;
   default clocking mon_cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // The counter saturates so that a long idle spell cannot wrap and fake a short dead time.
   always_ff @(posedge clk_in) begin
      prev_q <= switch_closed_out;
      if (rst_in || switch_closed_out != prev_q) begin
         still_q <= 9'h000;
      end else if (still_q != 9'h1FF) begin
         still_q <= still_q + 9'h001;
      end
   end
   rail_order_a:
      assert property ($rose(bias_rail_enable_out) |-> offset_rail_enable_out) else $error("bias before offset");
   bias_wait_a:
      assert property ($rose(offset_rail_enable_out) |-> !bias_rail_enable_out [*8]) else $error("bias too early");
   rail_pair_a:
      assert property (bias_rail_enable_out == mirror_reset_rail_enable_out) else $error("bias and reset differ");
   driver_gate_a:
      assert property (led_driver_enable_out |-> offset_rail_enable_out && bias_rail_enable_out
         && mirror_reset_rail_enable_out) else $error("driver on with rails down");
   fault_drop_a:
      assert property ($rose(rail_fault_latched_out) |-> !(offset_rail_enable_out || bias_rail_enable_out
         || mirror_reset_rail_enable_out || mirror_supply_enable_out)) else $error("rails kept after fault");
   reset_value_a:
      assert property ($fell(rst_in) |-> mirror_supply_enable_out && led_supply_enable_out)
         else $error("enable bits not set by reset");
   break_first_a:
      assert property ((switch_closed_out & ~prev_q) != 6'h00 |-> (prev_q & ~switch_closed_out) == 6'h00)
         else $error("open and close on one edge");
   dead_time_a:
      assert property ((switch_closed_out & ~prev_q) != 6'h00 |-> still_q >= {1'b0, break_before_make_delay_in})
         else $error("dead time too short");
   open_on_down_a:
      assert property ($fell(bias_rail_enable_out) |-> ##[0:2] switch_closed_out == 6'h00)
         else $error("switches left closed");
   release_a:
      assert property ($rose(serial_select_low_in) |-> ##[1:4] serial_data_oe_low_out) else $error("data not released");
   valid_pattern_a:
      assert property (current_code_valid_out |-> switch_closed_out != 6'h00) else $error("code with all open");
   cover property ($rose(led_driver_enable_out));
   cover property ($rose(rail_fault_latched_out));
   cover property ((switch_closed_out & ~prev_q) != 6'h00 && break_before_make_delay_in != 0);
endmodule // strobe_sequencer_monitor
`default_nettype wire

// File: bench/display_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module display_host_model (
   input wire logic clk_in,
   input wire logic serial_data_out,
   output logic request_out,
   output logic [1:0] colour_out,
   output logic sclk_out,
   output logic cs_low_out,
   output logic mosi_out
);
   initial begin
      request_out = 1'b0;
      colour_out = 2'h0;
      sclk_out = 1'b0;
      cs_low_out = 1'b1;
      mosi_out = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
      #2;
   endtask
   task automatic drive(input logic req, input logic [1:0] col);
      wait_clk(1);
      request_out = req;
      colour_out = col;
   endtask
   // The serial clock is slow against the system clock because the device samples it, and idles outside frames.
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      cs_low_out = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi_out = tx[i];
         wait_clk(8);
         sclk_out = 1'b1;
         wait_clk(8);
         rx[i] = serial_data_out;
         sclk_out = 1'b0;
      end
      wait_clk(8);
      cs_low_out = 1'b1;
      mosi_out = ~mosi_out;
   endtask
endmodule // display_host_model
`default_nettype wire

// File: bench/rgb_strobe_switch_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rgb_strobe_switch_sequencer_bench;
   import strobe_sequencer_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic projector_power_request_in, package_map_in, mirror_enable_write_in, mirror_enable_value_in;
   logic led_enable_write_in, led_enable_value_in, serial_clock_in, serial_select_low_in, serial_data_in;
   logic [1:0] colour_select_in;
   logic [2:0] rail_fault_in;
   logic [7:0] break_before_make_delay_in;
   logic [9:0] first_colour_current_code_in, second_colour_current_code_in, third_colour_current_code_in;
   logic [9:0] current_code_out;
   logic serial_data_out, serial_data_oe_low_out, serial_rx_valid_out, offset_rail_enable_out;
   logic bias_rail_enable_out, mirror_reset_rail_enable_out, led_driver_enable_out, full_active_state_out;
   logic mirror_supply_enable_out, led_supply_enable_out, rail_fault_latched_out, current_code_valid_out;
   logic [15:0] serial_rx_word_out, tx, rd;
   switch_map_t switch_closed_out, keep;
   logic [9:0] cc [3];
   logic [15:0] rx_q [$];
   int error_cnt = 0;
   int checked = 0;
   localparam switch_map_t MAP_T [8] = '{6'h07, 6'h0F, 6'h17, 6'h27, 6'h00, 6'h21, 6'h1C, 6'h1A};
   always #20 clk_in = ~clk_in;
   rgb_strobe_switch_sequencer #(.OFFSET_DELAY_CYCLES(50), .BIAS_DELAY_CYCLES(20), .POWER_DEGLITCH_CYCLES(5),
      .BBM_WIDTH(8)) u_dut (.*);
   display_host_model u_host (.clk_in(clk_in), .serial_data_out(serial_data_out),
      .request_out(projector_power_request_in), .colour_out(colour_select_in), .sclk_out(serial_clock_in),
      .cs_low_out(serial_select_low_in), .mosi_out(serial_data_in));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #2;
   endtask
   task automatic final_report();
      if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   function automatic logic [15:0] state_word();
      return {9'h0, led_supply_enable_out, rail_fault_latched_out, mirror_supply_enable_out,
         led_driver_enable_out, offset_rail_enable_out, bias_rail_enable_out, mirror_reset_rail_enable_out};
   endfunction
   task automatic power_up();
      int n;
      u_host.drive(1'b1, colour_select_in);
      for (n = 0; n < 100 && offset_rail_enable_out !== 1'b1; n++) tick(1);
      chk(16'(n >= 55 && n <= 62), 16'h0001);
      for (n = 0; n < 100 && bias_rail_enable_out !== 1'b1; n++) tick(1);
      chk(16'(n), 16'd20);
      chk(state_word(), 16'h005F);
      chk(16'(full_active_state_out), 16'h0001);
   endtask
   // Received words are matched in arrival order against what the host sent.
   always @(negedge clk_in) begin
      if (serial_rx_valid_out === 1'b1) begin
         if (rx_q.size() == 0) chk(16'h0001, 16'h0000);
         else chk(serial_rx_word_out, rx_q.pop_front());
      end
   end
   initial begin
      void'($urandom(95997));
      {mirror_enable_write_in, mirror_enable_value_in, led_enable_write_in, led_enable_value_in} = 4'h0;
      package_map_in = 1'b1;
      rail_fault_in = 3'h0;
      break_before_make_delay_in = 8'($urandom_range(6, 1));
      foreach (cc[i]) cc[i] = 10'($urandom);
      first_colour_current_code_in = cc[0];
      second_colour_current_code_in = cc[1];
      third_colour_current_code_in = cc[2];
      tick(3);
      rst_in = 1'b0;
      chk(state_word(), 16'h0050);
      u_host.drive(1'b1, 2'h0);
      tick(2);
      u_host.drive(1'b0, 2'h0);
      tick(80);
      chk(state_word(), 16'h0050);
      power_up();
      for (int m = 1; m >= 0; m--) begin
         package_map_in = m[0];
         for (int s = 0; s < 4; s++) begin
            keep = switch_closed_out & MAP_T[4*m+s];
            u_host.drive(1'b1, 2'(s));
            repeat (30) begin
               tick(1);
               chk({10'h0, switch_closed_out & keep}, {10'h0, keep});
            end
            chk({10'h0, switch_closed_out}, {10'h0, MAP_T[4*m+s]});
            chk({5'h0, current_code_valid_out, current_code_out}, (s == 0) ? 16'h0 : {5'h0, 1'b1, cc[s-1]});
         end
      end
      u_host.drive(1'b1, 2'h1);
      for (int i = 0; i < 20; i++) begin
         if (i == 3) u_host.drive(1'b1, 2'h3);
         else tick(1);
         chk({10'h0, switch_closed_out}, 16'h0027);
      end
      tx = 16'($urandom);
      rx_q.push_back(tx);
      u_host.xfer(tx, rd);
      chk(rd, 16'h7E27);
      tick(6);
      chk(16'(rx_q.size()), 16'h0000);
      chk(16'(serial_data_oe_low_out), 16'h0001);
      u_host.drive(1'b0, 2'h3);
      for (int i = 0; i < 40 && bias_rail_enable_out !== 1'b0; i++) tick(1);
      tick(2);
      chk(state_word(), 16'h0054);
      chk({10'h0, switch_closed_out}, 16'h0000);
      tick(25);
      chk(state_word(), 16'h0050);
      power_up();
      rail_fault_in = 3'h2;
      tick(4);
      chk(state_word(), 16'h0060);
      rail_fault_in = 3'h0;
      u_host.drive(1'b0, 2'h3);
      tick(20);
      chk(state_word(), 16'h0040);
      power_up();
      led_enable_write_in = 1'b1;
      tick(1);
      led_enable_write_in = 1'b0;
      tick(2);
      chk(state_word(), 16'h0017);
      mirror_enable_write_in = 1'b1;
      tick(1);
      mirror_enable_write_in = 1'b0;
      tick(40);
      chk(state_word(), 16'h0000);
      final_report();
   end
   initial begin
      #(40 * 20000);
      error_cnt++;
      final_report();
   end
endmodule // rgb_strobe_switch_sequencer_bench
bind rgb_strobe_switch_sequencer strobe_sequencer_monitor #(.BBM_WIDTH(BBM_WIDTH)) u_mon (.*);
`default_nettype wire
